// ==== pwp_pkg.sv ====
// Package of constants for the peripheral write-protect controller
package pwp_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int NUM_PERIPH = 6;
    localparam logic [7:0] OFF_CLEAR = 8'h00;
    localparam logic [7:0] OFF_SET = 8'h04;
    localparam logic [31:0] PROTECT_RESET = 32'h00000000;
    // Implemented protect bits: 6 down to 1
    localparam logic [31:0] IMPL_MASK = 32'h0000007E;
    localparam int BIT_POWER_MANAGER = 1;
    localparam int BIT_SYSTEM_CONTROL = 2;
    localparam int BIT_GENERIC_CLOCK = 3;
    localparam int BIT_WATCHDOG_GUARD = 4;
    localparam int BIT_CALENDAR = 5;
    localparam int BIT_EXT_IRQ_CTRL = 6;
    // Bus clock enables out of reset for the three instances
    localparam logic [2:0] BUS_CLOCK_EN_RESET = 3'h3;
    localparam int INSTANCE_INDEX = 0;
endpackage

// ==== pwp_lane_if.sv ====
// Interface carrying byte-lane write data between the lane mask and top
`timescale 1ns/10ps
interface pwp_lane_if;
    logic [31:0] wdata;
    logic [3:0] strobe;
    logic [31:0] mask;
    modport source (output mask, input wdata, input strobe);
    modport sink (input mask, output wdata, output strobe);
endinterface

// ==== pwp_lane_mask.sv ====
// Byte-lane expansion of write strobes into a bit mask
`timescale 1ns/10ps
module pwp_lane_mask (
    // Lane carrier
    pwp_lane_if.source lanes
);
    // Each strobe enables its own byte so 8 and 16 bit pieces can be written alone
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lanes.mask[i*8 +: 8] = lanes.strobe[i] ? lanes.wdata[i*8 +: 8] : 8'h00;
        end
    end
endmodule

// ==== pwp_access_protector.sv ====
// Top of the peripheral write-protect controller, one instance per bridge
`timescale 1ns/10ps
module pwp_access_protector (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port, one-cycle access with byte strobes
    input wire logic regSel,
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [3:0] regStrobe,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    output logic regReady,
    output logic regError,
    // Guarded peripheral write path
    input wire logic perWrite,
    input wire logic [2:0] perIndex,
    input wire logic perDebug,
    output logic perWriteGo,
    output logic perError,
    // Bus clock enables for the three instances
    output logic [2:0] busClockEn,
    // Protect vector to the guarded blocks
    output logic [6:1] protectVec
);
    // Protect state and its next value
    logic [31:0] protect;
    logic [31:0] next_protect;
    // Register decode and checks
    logic [31:0] wmask;
    logic hitClear;
    logic hitSet;
    logic mappedAddr;
    logic readHit;
    logic clearErr;
    logic setErr;
    logic next_regError;
    logic [31:0] next_regRdata;
    // Named view of the guarded blocks
    logic powerManagerBit;
    logic systemControlBit;
    logic genericClockBit;
    logic watchdogGuardBit;
    logic calendarBit;
    logic extIrqCtrlBit;
    // Peripheral gate
    logic perProtected;
    logic next_perWriteGo;
    logic next_perError;
    pwp_lane_if lanes ();

    ////////////////////////////////////////////////////////////////////////
    // Lane masking, unassigned bits dropped so they never flag an error
    // A byte or halfword access leaves the other lanes zero, so they neither set, clear nor flag
    assign lanes.wdata = regWdata;
    assign lanes.strobe = regStrobe;
    pwp_lane_mask laneMask (
        .lanes(lanes)
    );
    assign wmask = lanes.mask & pwp_pkg::IMPL_MASK;

    ////////////////////////////////////////////////////////////////////////
    // Address decode; only the two word offsets are mapped
    // Other offsets still get a ready, so a stray access never stalls the bridge
    assign mappedAddr = (regAddr == pwp_pkg::OFF_CLEAR) || (regAddr == pwp_pkg::OFF_SET);
    assign hitClear = regSel && regWrite && (regAddr == pwp_pkg::OFF_CLEAR);
    assign hitSet = regSel && regWrite && (regAddr == pwp_pkg::OFF_SET);
    assign readHit = regSel && !regWrite && mappedAddr;

    // Double unprotect and double protect checks, against the bits before the write
    // They catch software that lost track of whether a block is guarded
    assign clearErr = hitClear && |(wmask & ~protect);
    assign setErr = hitSet && |(wmask & protect);
    assign next_regError = clearErr || setErr;

    // Next protect vector; the write still lands even when it flags an error
    // Set and clear are idempotent, so landing the write costs nothing
    always_comb begin
        next_protect = protect;
        if (hitClear) begin
            next_protect = protect & ~wmask;
        end else if (hitSet) begin
            next_protect = protect | wmask;
        end
    end

    // Read data; both offsets show one vector, unassigned positions read zero
    always_comb begin
        next_regRdata = 32'h00000000;
        if (readHit) begin
            next_regRdata = protect & pwp_pkg::IMPL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Named view of the protect vector, one signal per guarded block
    assign powerManagerBit = protect[pwp_pkg::BIT_POWER_MANAGER];
    assign systemControlBit = protect[pwp_pkg::BIT_SYSTEM_CONTROL];
    assign genericClockBit = protect[pwp_pkg::BIT_GENERIC_CLOCK];
    assign watchdogGuardBit = protect[pwp_pkg::BIT_WATCHDOG_GUARD];
    assign calendarBit = protect[pwp_pkg::BIT_CALENDAR];
    assign extIrqCtrlBit = protect[pwp_pkg::BIT_EXT_IRQ_CTRL];

    // Protect bit of the addressed peripheral
    // Codes 0 and 7 name no block on this bridge, so they are never guarded
    always_comb begin
        unique case (perIndex)
            3'(pwp_pkg::BIT_POWER_MANAGER): perProtected = powerManagerBit;
            3'(pwp_pkg::BIT_SYSTEM_CONTROL): perProtected = systemControlBit;
            3'(pwp_pkg::BIT_GENERIC_CLOCK): perProtected = genericClockBit;
            3'(pwp_pkg::BIT_WATCHDOG_GUARD): perProtected = watchdogGuardBit;
            3'(pwp_pkg::BIT_CALENDAR): perProtected = calendarBit;
            3'(pwp_pkg::BIT_EXT_IRQ_CTRL): perProtected = extIrqCtrlBit;
            default: perProtected = 1'b0;
        endcase
    end

    // Gate decision, taken on the bits before any same-cycle register write
    // The debugger path is trusted so it can repair a block that software locked
    assign next_perWriteGo = perWrite && (perDebug || !perProtected);
    assign next_perError = perWrite && !perDebug && perProtected;

    ////////////////////////////////////////////////////////////////////////
    // Protect state, reset to all unprotected
    // Only bits 6 to 1 ever move; the rest stay at their reset zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            protect <= pwp_pkg::PROTECT_RESET;
        end else begin
            protect <= next_protect;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready answers every access, mapped or not, one cycle after it is taken
    // No wait states: the whole decision fits in one cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            regReady <= 1'b0;
        end else begin
            regReady <= regSel;
        end
    end

    // Error rides with ready and lasts one cycle
    // The bridge turns it into the bus error response
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            regError <= 1'b0;
        end else begin
            regError <= next_regError;
        end
    end

    // Read data, held at zero outside reads
    // Keeping it zero means a stale vector never leaks onto a write answer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            regRdata <= 32'h00000000;
        end else begin
            regRdata <= next_regRdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write allowed pulse to the guarded block
    // One cycle of latency, traded for a clean registered strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            perWriteGo <= 1'b0;
        end else begin
            perWriteGo <= next_perWriteGo;
        end
    end

    // Refusal pulse, turned into a bus error by the bridge
    // The refused data is simply never passed on, so the block keeps its registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            perError <= 1'b0;
        end else begin
            perError <= next_perError;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Exported vector; loaded from next_protect, it matches the bits the gate uses in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            protectVec <= 6'h00;
        end else begin
            protectVec <= next_protect[6:1];
        end
    end

    // Clock enables; only the power manager changes them and that path lies outside
    // The clock keeps running in sleep while its source runs, so nothing here gates it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busClockEn <= pwp_pkg::BUS_CLOCK_EN_RESET;
        end else begin
            busClockEn <= busClockEn;
        end
    end
endmodule

// ==== pwp_assertions.sv ====
// Checker of the write-protect controller ports
`timescale 1ns/10ps
module pwp_assertions (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic regSel,
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [3:0] regStrobe,
    input wire logic [31:0] regWdata,
    input wire logic [31:0] regRdata,
    input wire logic regReady,
    input wire logic regError,
    // Guarded peripheral write path
    input wire logic perWrite,
    input wire logic [2:0] perIndex,
    input wire logic perDebug,
    input wire logic perWriteGo,
    input wire logic perError,
    // Clock enables and protect vector
    input wire logic [2:0] busClockEn,
    input wire logic [6:1] protectVec
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Both registers keep their bits in lane 0, so only that strobe matters here
    wire lowWr = regSel && regWrite && regStrobe[0];
    wire [6:1] wb = regWdata[6:1];
    wire clrWr = lowWr && regAddr == pwp_pkg::OFF_CLEAR;
    wire setWr = lowWr && regAddr == pwp_pkg::OFF_SET;
    a_ready_after: assert property (regSel |=> regReady)
        else $error("register access got no ready");
    a_clear_drops: assert property (clrWr |=> !(protectVec & $past(wb)))
        else $error("clear write left a bit set");
    a_set_raises: assert property (setWr |=> &(protectVec | ~$past(wb)))
        else $error("set write left a bit clear");
    a_zero_keeps: assert property (regSel && regWrite && wb == 6'h00 |=> $stable(protectVec))
        else $error("zero write moved protect bits");
    a_read_same: assert property (regSel && !regWrite && (regAddr & 8'hFB) == 8'h00
        |=> regRdata == {25'h0, protectVec, 1'b0})
        else $error("read data differs from protect vector");
    a_block_write: assert property (perWrite && !perDebug && protectVec[perIndex] |=> perError && !perWriteGo)
        else $error("guarded write was not refused");
    a_debug_pass: assert property (perWrite && perDebug |=> perWriteGo && !perError)
        else $error("debugger write was refused");
    a_double_set: assert property (setWr && |(wb & protectVec) |=> regError)
        else $error("double protect gave no error");
    a_double_clr: assert property (clrWr && |(wb & ~protectVec) |=> regError)
        else $error("double unprotect gave no error");
    a_clock_fixed: assert property (busClockEn == 3'h3)
        else $error("bus clock enables moved");
    a_spare_zero: assert property (regRdata[31:7] == 25'h0 && !regRdata[0])
        else $error("unassigned bit read as one");
    a_quiet_write: assert property (regSel && regWrite && !(clrWr && |(wb & ~protectVec))
        && !(setWr && |(wb & protectVec)) |=> !regError)
        else $error("error without a double operation");
    a_reset_clear: assert property ($rose(rst_n) |-> protectVec == 6'h00 && !regReady && !perError)
        else $error("outputs not clear after reset");
    cover property (lowWr ##1 regError);
    cover property (perWrite && !perDebug ##1 perError);
    cover property (perWrite && perDebug ##1 perWriteGo);
    cover property (perWrite && perDebug && protectVec[perIndex] ##1 perWriteGo);
endmodule
bind pwp_access_protector pwp_assertions i_chk (.*);

// ==== pwp_far_master.sv ====
// Model of the master that issues guarded peripheral writes
`timescale 1ns/10ps
module pwp_far_master (
    // Clock
    input wire logic clock,
    // Request from the bench
    input wire logic kick,
    input wire logic dbg,
    input wire logic [2:0] idx,
    // Guarded write request to the controller
    output logic perWrite = 1'b0,
    output logic perDebug = 1'b0,
    output logic [2:0] perIndex = 3'h0
);
    // One-cycle request; idle qualifiers toggle so a stale value is never trusted
    always_ff @(posedge clock) begin
        perWrite <= kick;
        perIndex <= kick ? idx : ~perIndex;
        perDebug <= kick ? dbg : ~perDebug;
    end
endmodule

// ==== peripheral_write_protect_bench.sv ====
// Self-checking bench of the write-protect controller
`timescale 1ns/10ps
module peripheral_write_protect_bench;
    logic clock = 1'b0, rst_n = 1'b0, regSel = 1'b0, regWrite = 1'b0, kick = 1'b0, dbg = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [3:0] regStrobe = 4'h0;
    logic [31:0] regWdata = 32'h0, regRdata, seed = 32'hC9D0;
    logic [2:0] idx = 3'h1, perIndex, busClockEn;
    logic regReady, regError, perWrite, perDebug, perWriteGo, perError;
    logic [6:1] protectVec, prot = 6'h00;
    logic [43:0] notes[$];
    logic [43:0] got, want;
    int n_fail = 0, checks_done = 0;
    pwp_access_protector i_dut (.*);
    pwp_far_master i_far (.*);
    // 50 MHz clock
    initial forever #10 clock = ~clock;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    // Register access; the expected answer is noted before the request goes out
    task automatic rw(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [6:1] b;
        logic e;
        b = d[6:1] & {6{s[0]}};
        e = w && (a == 8'h04 ? |(b & prot) : a == 8'h00 && |(b & ~prot));
        prot = (w && a == 8'h04) ? prot | b : (w && a == 8'h00) ? prot & ~b : prot;
        notes.push_back({e, 2'b00, pwp_pkg::BUS_CLOCK_EN_RESET, prot,
            (!w && (a & 8'hFB) == 8'h00) ? {25'h0, prot, 1'b0} : 32'h0});
        @(posedge clock);
        {regSel, regWrite, regAddr, regStrobe, regWdata} <= {1'b1, w, a, s, d};
        @(posedge clock);
        regSel <= 1'b0;
    endtask
    // Peripheral write through the far-side master
    task automatic pw(input logic [2:0] i, input logic g);
        notes.push_back({1'b0, !(g || !prot[i]), g || !prot[i], pwp_pkg::BUS_CLOCK_EN_RESET, prot, 32'h0});
        @(posedge clock);
        {kick, idx, dbg} <= {1'b1, i, g};
        @(posedge clock);
        kick <= 1'b0;
    endtask
    task automatic test_done();
        // An answer that never came leaves its note behind
        if (notes.size() != 0) n_fail++;
        if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Every answer pulse is matched against the oldest note
    always @(negedge clock) begin
        if (regReady === 1'b1 || perWriteGo === 1'b1 || perError === 1'b1) begin
            got = {regError, perError, perWriteGo, busClockEn, protectVec, regRdata};
            want = 44'h00000000000;
            if (notes.size() != 0) want = notes.pop_front();
            checks_done++;
            if (got !== want) begin
                n_fail++;
                $display("[FAIL] %0t got %h want %h", $time, got, want);
            end
        end
    end
    // Reset, fixed cases, then random traffic over all four word offsets
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rw(1'b0, 8'h04, 4'hF, 32'h0);
        rw(1'b1, 8'h04, 4'h2, 32'hFFFFFFFF);
        for (int n = 0; n < 80; n++) begin
            seed = xs(seed);
            rw(seed[0], {4'h0, seed[2:1], 2'b00}, seed[0] ? seed[11:8] : 4'hF, seed);
            pw(3'(seed[15:12] % 6 + 1), seed[3]);
        end
        repeat (3) @(posedge clock);
        // Mid-run reset, then a paired protect and unprotect that reads the clear register first
        rst_n <= 1'b0;
        prot = 6'h00;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rw(1'b0, 8'h00, 4'hF, 32'h0);
        rw(1'b0, 8'h04, 4'hF, 32'h0);
        rw(1'b1, 8'h04, 4'h1, 32'h00000010);
        pw(3'h4, 1'b0);
        pw(3'h4, 1'b1);
        rw(1'b1, 8'h04, 4'h1, 32'h00000010);
        rw(1'b1, 8'h00, 4'h1, 32'h00000010);
        rw(1'b1, 8'h00, 4'h1, 32'h00000010);
        repeat (3) @(posedge clock);
        test_done();
    end
    // Hang guard, well beyond the expected run length
    initial begin
        repeat (2000) @(posedge clock);
        n_fail++;
        test_done();
    end
endmodule
